// file: inc/maua_pkg.sv
// Package for the master alarm update annunciator
package maua_pkg;

    localparam int MAUA_NUM_KINDS = 8;
    localparam int MAUA_NUM_OUTS = 3;
    localparam int MAUA_NUM_EVT = 5;

    // Event kind bit positions
    localparam int MAUA_KIND_FAULT = 0;
    localparam int MAUA_KIND_INHIBIT = 1;
    localparam int MAUA_KIND_FIRST = 2;
    localparam int MAUA_KIND_SECOND = 3;
    localparam int MAUA_KIND_UPPER = 4;
    localparam int MAUA_KIND_SHORT_TERM = 5;
    localparam int MAUA_KIND_LONG_TERM = 6;
    localparam int MAUA_KIND_RATE = 7;

    // Output indices
    localparam int MAUA_OUT_TRANSISTOR = 0;
    localparam int MAUA_OUT_RELAY = 1;
    localparam int MAUA_OUT_SOUNDER = 2;

    // Interrupt status bits
    localparam int MAUA_EVT_NEW = 0;
    localparam int MAUA_EVT_CLEAR = 1;
    localparam int MAUA_EVT_ACCEPT = 2;
    localparam int MAUA_EVT_RESET = 3;
    localparam int MAUA_EVT_UNMAPPED = 4;

    // Register byte addresses
    localparam logic [7:0] MAUA_ADDR_CTRL = 8'h00;
    localparam logic [7:0] MAUA_ADDR_MASK0 = 8'h04;
    localparam logic [7:0] MAUA_ADDR_ACT0 = 8'h10;
    localparam logic [7:0] MAUA_ADDR_STATUS = 8'h1c;
    localparam logic [7:0] MAUA_ADDR_IRQ_STAT = 8'h20;
    localparam logic [7:0] MAUA_ADDR_IRQ_MASK = 8'h24;
    localparam logic [7:0] MAUA_ADDR_EVENTS = 8'h28;

    // Reset values
    localparam logic [7:0] MAUA_MASK_RST = 8'hff;
    localparam logic [1:0] MAUA_POL_RST = 2'h0;

    // Timing
    localparam int MAUA_CLK_MHZ = 250;
    localparam int MAUA_DEBOUNCE_US = 10;
    localparam int MAUA_DEBOUNCE_CYC = MAUA_DEBOUNCE_US * MAUA_CLK_MHZ;
    localparam int MAUA_PULSE_HALF_MS = 250;
    localparam int MAUA_PULSE_HALF_CYC = MAUA_PULSE_HALF_MS * 1000 * MAUA_CLK_MHZ;
    localparam int MAUA_MRST_PULSE_CYC = 1;

    typedef enum logic [1:0]
    {
        MAUA_ACT_PULSE = 2'h0,
        MAUA_ACT_STEADY = 2'h1,
        MAUA_ACT_OFF = 2'h2,
        MAUA_ACT_KEEP = 2'h3
    } maua_action_t;

    // Actions for one output, one per trigger
    typedef struct packed
    {
        maua_action_t on_accept;
        maua_action_t on_clear;
        maua_action_t on_new;
    } maua_cfg_t;

    typedef enum logic [1:0]
    {
        MAUA_DRV_OFF,
        MAUA_DRV_STEADY,
        MAUA_DRV_PULSE
    } maua_drv_t;

    localparam maua_cfg_t MAUA_CFG_TRANSISTOR_RST = '{MAUA_ACT_STEADY, MAUA_ACT_KEEP,
        MAUA_ACT_PULSE};
    localparam maua_cfg_t MAUA_CFG_RELAY_RST = '{MAUA_ACT_OFF, MAUA_ACT_KEEP, MAUA_ACT_STEADY};
    localparam maua_cfg_t MAUA_CFG_SOUNDER_RST = '{MAUA_ACT_OFF, MAUA_ACT_KEEP, MAUA_ACT_STEADY};

endpackage : maua_pkg

// file: hdl/maua_top.sv
// Master alarm update annunciator with Avalon-MM register slave
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module maua_top
    import maua_pkg::*;
#(
    parameter int PULSE_HALF_CYC = MAUA_PULSE_HALF_CYC,
    parameter int DEBOUNCE_CYC = MAUA_DEBOUNCE_CYC
)
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // Per-kind rack-wide alarm levels, from outside the clock domain
    input wire logic [MAUA_NUM_KINDS-1:0] alarm_kinds_i,
    // Accept and reset pins, remote switch and panel button wired together
    input wire logic accept_pin_i,
    input wire logic reset_pin_i,
    // Contact sense strap: high means normally closed
    input wire logic relay_nc_link_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic transistor_on_o,
    output logic panel_lamp_o,
    output logic relay_coil_o,
    output logic relay_contact_closed_o,
    output logic sounder_on_o,
    output logic master_reset_o,
    output logic irq_o
);

    localparam int PW = $clog2(PULSE_HALF_CYC + 1);
    localparam int DW = $clog2(DEBOUNCE_CYC + 1);

    function automatic maua_drv_t apply_action(input maua_action_t act, input maua_drv_t cur,
        input logic still_present);
        maua_drv_t res;
        res = cur;
        case (act)
            MAUA_ACT_PULSE: res = MAUA_DRV_PULSE;
            MAUA_ACT_STEADY: res = still_present ? MAUA_DRV_STEADY : MAUA_DRV_OFF;
            MAUA_ACT_OFF: res = MAUA_DRV_OFF;
            default: res = cur;
        endcase
        return res;
    endfunction : apply_action

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Reset release
    logic rst_s1_r;
    logic rst_s2_r;
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire logic rst_n = rst_s2_r;

    // Input synchronisers
    logic [MAUA_NUM_KINDS+2:0] sync1_r;
    logic [MAUA_NUM_KINDS+2:0] sync2_r;
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else if (clk_en_i)
        begin
            sync1_r <= {relay_nc_link_i, reset_pin_i, accept_pin_i, alarm_kinds_i};
            sync2_r <= sync1_r;
        end
    end
    wire logic [MAUA_NUM_KINDS-1:0] kinds_s = sync2_r[MAUA_NUM_KINDS-1:0];
    wire logic relay_nc_s = sync2_r[MAUA_NUM_KINDS+2];

    // Registers
    logic [1:0] pol_low_r;
    logic [MAUA_NUM_KINDS-1:0] sel_mask_r [MAUA_NUM_OUTS];
    maua_cfg_t cfg_r [MAUA_NUM_OUTS];
    logic [MAUA_NUM_EVT-1:0] irq_stat_r;
    logic [MAUA_NUM_EVT-1:0] irq_mask_r;
    logic sw_accept_r;

    wire logic bus_wr = avs_write_i && !avs_waitrequest_o;
    wire logic bus_rd = avs_read_i && !avs_waitrequest_o;
    wire logic mask_hit = avs_address_i >= MAUA_ADDR_MASK0 && avs_address_i < MAUA_ADDR_ACT0;
    wire logic act_hit = avs_address_i >= MAUA_ADDR_ACT0 && avs_address_i < MAUA_ADDR_STATUS;
    wire logic [1:0] mask_idx = 2'((avs_address_i - MAUA_ADDR_MASK0) >> 2);
    wire logic [1:0] act_idx = 2'((avs_address_i - MAUA_ADDR_ACT0) >> 2);

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pol_low_r <= MAUA_POL_RST;
            sw_accept_r <= 1'b0;
            irq_mask_r <= '0;
            for (int i = 0; i < MAUA_NUM_OUTS; i++)
            begin
                sel_mask_r[i] <= MAUA_MASK_RST;
            end
            cfg_r[MAUA_OUT_TRANSISTOR] <= MAUA_CFG_TRANSISTOR_RST;
            cfg_r[MAUA_OUT_RELAY] <= MAUA_CFG_RELAY_RST;
            cfg_r[MAUA_OUT_SOUNDER] <= MAUA_CFG_SOUNDER_RST;
        end
        else if (clk_en_i)
        begin
            sw_accept_r <= 1'b0;
            if (bus_wr && avs_address_i == MAUA_ADDR_CTRL)
            begin
                pol_low_r <= 2'(merge_bytes({30'h0, pol_low_r}, avs_writedata_i,
                    avs_byteenable_i));
                sw_accept_r <= avs_byteenable_i[0] && avs_writedata_i[8];
            end
            if (bus_wr && mask_hit && mask_idx < 2'(MAUA_NUM_OUTS))
            begin
                sel_mask_r[mask_idx] <= 8'(merge_bytes({24'h0, sel_mask_r[mask_idx]},
                    avs_writedata_i, avs_byteenable_i));
            end
            if (bus_wr && act_hit && act_idx < 2'(MAUA_NUM_OUTS))
            begin
                cfg_r[act_idx] <= maua_cfg_t'(6'(merge_bytes({26'h0, cfg_r[act_idx]},
                    avs_writedata_i, avs_byteenable_i)));
            end
            if (bus_wr && avs_address_i == MAUA_ADDR_IRQ_MASK)
            begin
                irq_mask_r <= MAUA_NUM_EVT'(merge_bytes({27'h0, irq_mask_r},
                    avs_writedata_i, avs_byteenable_i));
            end
        end
    end

    // Control inputs: polarity, debounce, edge
    logic [1:0] ctl_stable_r;
    logic [1:0] ctl_edge_r;
    logic [DW-1:0] db_cnt_r [2];
    wire logic [1:0] ctl_raw = sync2_r[MAUA_NUM_KINDS +: 2] ^ pol_low_r;
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_stable_r <= 2'h0;
            ctl_edge_r <= 2'h0;
            db_cnt_r[0] <= '0;
            db_cnt_r[1] <= '0;
        end
        else if (clk_en_i)
        begin
            for (int c = 0; c < 2; c++)
            begin
                ctl_edge_r[c] <= 1'b0;
                if (ctl_raw[c] == ctl_stable_r[c])
                begin
                    db_cnt_r[c] <= '0;
                end
                else if (db_cnt_r[c] == DW'(DEBOUNCE_CYC - 1))
                begin
                    db_cnt_r[c] <= '0;
                    ctl_stable_r[c] <= ctl_raw[c];
                    ctl_edge_r[c] <= ctl_raw[c];
                end
                else
                begin
                    db_cnt_r[c] <= db_cnt_r[c] + 1'b1;
                end
            end
        end
    end
    // A master reset counts as an accept too
    wire logic accept_evt = ctl_edge_r[0] || ctl_edge_r[1] || sw_accept_r;
    wire logic reset_evt = ctl_edge_r[1];

    // Edge detection of event kinds
    logic [MAUA_NUM_KINDS-1:0] kinds_prev_r;
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kinds_prev_r <= '0;
        end
        else if (clk_en_i)
        begin
            kinds_prev_r <= kinds_s;
        end
    end
    wire logic [MAUA_NUM_KINDS-1:0] kinds_new = kinds_s & ~kinds_prev_r;
    wire logic [MAUA_NUM_KINDS-1:0] kinds_gone = ~kinds_s & kinds_prev_r;

    // Update functions
    maua_drv_t drv_r [MAUA_NUM_OUTS];
    logic [MAUA_NUM_OUTS-1:0] any_new;
    logic [MAUA_NUM_OUTS-1:0] any_gone;
    logic [MAUA_NUM_OUTS-1:0] present;
    always_comb
    begin
        for (int o = 0; o < MAUA_NUM_OUTS; o++)
        begin
            any_new[o] = |(kinds_new & sel_mask_r[o]);
            any_gone[o] = |(kinds_gone & sel_mask_r[o]);
            present[o] = |(kinds_s & sel_mask_r[o]);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int o = 0; o < MAUA_NUM_OUTS; o++)
            begin
                drv_r[o] <= MAUA_DRV_OFF;
            end
        end
        else if (clk_en_i)
        begin
            for (int o = 0; o < MAUA_NUM_OUTS; o++)
            begin
                // New events win over accept in the same cycle
                if (any_new[o])
                begin
                    drv_r[o] <= apply_action(cfg_r[o].on_new, drv_r[o], 1'b1);
                end
                else if (accept_evt)
                begin
                    drv_r[o] <= apply_action(cfg_r[o].on_accept, drv_r[o],
                        present[o]);
                end
                else if (any_gone[o])
                begin
                    drv_r[o] <= apply_action(cfg_r[o].on_clear, drv_r[o], 1'b1);
                end
            end
        end
    end

    // Shared pulse generator, 50 percent duty
    logic [PW-1:0] pulse_cnt_r;
    logic pulse_ph_r;
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pulse_cnt_r <= '0;
            pulse_ph_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (pulse_cnt_r == PW'(PULSE_HALF_CYC - 1))
            begin
                pulse_cnt_r <= '0;
                pulse_ph_r <= ~pulse_ph_r;
            end
            else
            begin
                pulse_cnt_r <= pulse_cnt_r + 1'b1;
            end
        end
    end

    logic [MAUA_NUM_OUTS-1:0] drv_level;
    always_comb
    begin
        for (int o = 0; o < MAUA_NUM_OUTS; o++)
        begin
            case (drv_r[o])
                MAUA_DRV_STEADY: drv_level[o] = 1'b1;
                MAUA_DRV_PULSE: drv_level[o] = pulse_ph_r;
                default: drv_level[o] = 1'b0;
            endcase
        end
    end

    // Outputs and interrupt status
    logic [MAUA_NUM_EVT-1:0] evt_set;
    always_comb
    begin
        evt_set = '0;
        evt_set[MAUA_EVT_NEW] = |any_new;
        evt_set[MAUA_EVT_CLEAR] = |any_gone;
        evt_set[MAUA_EVT_ACCEPT] = accept_evt;
        evt_set[MAUA_EVT_RESET] = reset_evt;
        evt_set[MAUA_EVT_UNMAPPED] = (bus_wr || bus_rd) && !(avs_address_i == MAUA_ADDR_CTRL
            || mask_hit || act_hit || avs_address_i == MAUA_ADDR_STATUS
            || avs_address_i == MAUA_ADDR_IRQ_STAT || avs_address_i == MAUA_ADDR_IRQ_MASK
            || avs_address_i == MAUA_ADDR_EVENTS);
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            transistor_on_o <= 1'b0;
            panel_lamp_o <= 1'b0;
            relay_coil_o <= 1'b0;
            relay_contact_closed_o <= 1'b0;
            sounder_on_o <= 1'b0;
            master_reset_o <= 1'b0;
            irq_stat_r <= '0;
            irq_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            transistor_on_o <= drv_level[MAUA_OUT_TRANSISTOR];
            panel_lamp_o <= drv_level[MAUA_OUT_TRANSISTOR];
            relay_coil_o <= drv_level[MAUA_OUT_RELAY];
            relay_contact_closed_o <= drv_level[MAUA_OUT_RELAY] ^ relay_nc_s;
            sounder_on_o <= drv_level[MAUA_OUT_SOUNDER];
            // Rack cards clear their non-active latches on this pulse
            master_reset_o <= reset_evt;
            // Hardware set beats a write-one clear
            if (bus_wr && avs_address_i == MAUA_ADDR_IRQ_STAT && avs_byteenable_i[0])
            begin
                irq_stat_r <= (irq_stat_r & ~avs_writedata_i[MAUA_NUM_EVT-1:0]) | evt_set;
            end
            else
            begin
                irq_stat_r <= irq_stat_r | evt_set;
            end
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Bus slave: one wait cycle, then answer
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end
        else if (clk_en_i)
        begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o)
            begin
                avs_readdata_o <= 32'h0;
                if (avs_address_i == MAUA_ADDR_CTRL)
                    avs_readdata_o <= {30'h0, pol_low_r};
                else if (mask_hit && mask_idx < 2'(MAUA_NUM_OUTS))
                    avs_readdata_o <= {24'h0, sel_mask_r[mask_idx]};
                else if (act_hit && act_idx < 2'(MAUA_NUM_OUTS))
                    avs_readdata_o <= {26'h0, cfg_r[act_idx]};
                else if (avs_address_i == MAUA_ADDR_STATUS)
                    avs_readdata_o <= {22'h0, drv_r[2], drv_r[1], drv_r[0], ctl_stable_r,
                        relay_nc_s, 1'b0};
                else if (avs_address_i == MAUA_ADDR_IRQ_STAT)
                    avs_readdata_o <= {27'h0, irq_stat_r};
                else if (avs_address_i == MAUA_ADDR_IRQ_MASK)
                    avs_readdata_o <= {27'h0, irq_mask_r};
                else if (avs_address_i == MAUA_ADDR_EVENTS)
                    avs_readdata_o <= {24'h0, kinds_s};
            end
        end
    end

endmodule : maua_top

// file: bench/maua_monitor.sv
// Port-level checker for the alarm update annunciator
`timescale 1ns/100ps
module maua_monitor
#(
    parameter int DEBOUNCE_CYC = 3
)
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic reset_pin_i,
    input wire logic relay_nc_link_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic transistor_on_o,
    input wire logic panel_lamp_o,
    input wire logic relay_coil_o,
    input wire logic relay_contact_closed_o,
    input wire logic master_reset_o
);
    // Sync, filter and edge stages add a few cycles past the filter length
    localparam int MRST_LAT = DEBOUNCE_CYC + 10;
    logic [7:0] quiet_r;
    logic pin_last_r;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // A polarity write can move the filtered level as well as the pin
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            quiet_r <= 8'h00;
            pin_last_r <= 1'b0;
        end
        else
        begin
            pin_last_r <= reset_pin_i;
            if (reset_pin_i != pin_last_r || avs_write_i)
                quiet_r <= 8'h00;
            else if (quiet_r != 8'hff)
                quiet_r <= quiet_r + 8'h01;
        end
    end
    sequence bus_req_s;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence bus_ans_s;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    lamp_follow_a: assert property (panel_lamp_o == transistor_on_o)
        else $error("lamp differs from transistor");
    contact_sense_a: assert property (
        ($stable(relay_nc_link_i) && $stable(relay_coil_o))[*8]
        |-> relay_contact_closed_o == (relay_coil_o ^ relay_nc_link_i))
        else $error("contact sense wrong");
    mrst_pulse_a: assert property (master_reset_o |=> !master_reset_o)
        else $error("master reset longer than one cycle");
    mrst_cause_a: assert property (master_reset_o |-> quiet_r < MRST_LAT)
        else $error("master reset without pin edge");
    bus_answer_a: assert property (bus_req_s |=> bus_ans_s)
        else $error("bus answer late or long");
    bus_idle_a: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("waitrequest low while idle");
    bus_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low two cycles");
    unmapped_zero_a: assert property (
        avs_read_i && avs_waitrequest_o && avs_address_i == 8'h40
        |=> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule : maua_monitor

// file: bench/maua_rack_model.sv
// Behavioural rack of control cards giving per-kind alarm levels
`timescale 1ns/100ps
module maua_rack_model
    import maua_pkg::*;
(
    input wire logic clk_i,
    input wire logic master_reset_i,
    output logic [MAUA_NUM_KINDS-1:0] kinds_o
);
    logic [MAUA_NUM_KINDS-1:0] live_r [4] = '{4{8'h00}};
    logic [MAUA_NUM_KINDS-1:0] held_r [4] = '{4{8'h00}};
    // Latched alarms outlive their cause until the rack-wide reset
    always @(posedge clk_i)
        if (master_reset_i)
            held_r <= '{4{8'h00}};
    always_comb
        kinds_o = live_r[0] | live_r[1] | live_r[2] | live_r[3] |
            held_r[0] | held_r[1] | held_r[2] | held_r[3];
    task automatic raise(input int ch, input int k);
        @(posedge clk_i);
        live_r[ch][k] <= 1'b1;
    endtask : raise
    task automatic fall(input int ch, input int k, input logic latch);
        @(posedge clk_i);
        live_r[ch][k] <= 1'b0;
        held_r[ch][k] <= latch;
    endtask : fall
endmodule : maua_rack_model

// file: bench/maua_top_tb.sv
// Self-checking bench for the alarm update annunciator
`timescale 1ns/100ps
module maua_top_tb
    import maua_pkg::*;
;
    localparam int HALF = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic acc = 1'b0;
    logic rsp = 1'b0;
    logic link = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic [31:0] q;
    logic [31:0] r;
    logic [31:0] seed = 32'h5d;
    logic [7:0] kinds;
    logic wreq, tr, lamp, coil, cont, snd, mrst, irq;
    logic [1:0] pol = 2'h0;
    int failures = 0;
    int cmp_count = 0;
    int drv [3] = '{0, 0, 0};
    logic [7:0] msk [3] = '{8'hff, 8'hff, 8'hff};
    logic [5:0] act [3];
    maua_top #(.PULSE_HALF_CYC(HALF), .DEBOUNCE_CYC(3)) maua_top_inst (
        .core_clk_i(clk), .rstn_i(rstn), .clk_en_i(1'b1), .alarm_kinds_i(kinds),
        .accept_pin_i(acc), .reset_pin_i(rsp), .relay_nc_link_i(link),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .transistor_on_o(tr), .panel_lamp_o(lamp), .relay_coil_o(coil),
        .relay_contact_closed_o(cont), .sounder_on_o(snd), .master_reset_o(mrst),
        .irq_o(irq));
    maua_rack_model maua_rack_model_inst (.clk_i(clk), .master_reset_i(mrst), .kinds_o(kinds));
    initial
        forever #2 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk);
            if (wreq === 1'b0)
                break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 40)
        begin
            failures++;
            wrap_up();
        end
    endtask : bus
    task automatic reg_rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : reg_rd
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : reg_wr
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift
    // Reference drive state: 0 off, 1 steady, 2 pulse
    task automatic mdl(input int trig, input logic [7:0] bits);
        int a;
        for (int o = 0; o < 3; o++)
        begin
            a = act[o][2*trig +: 2];
            if (trig == 0 && (bits & msk[o]) == 8'h00)
                continue;
            if (a == 0)
                drv[o] = 2;
            else if (a == 1)
                drv[o] = (trig == 2 && (kinds & msk[o]) == 8'h00) ? 0 : 1;
            else if (a == 2)
                drv[o] = 0;
        end
    endtask : mdl
    task automatic chk();
        logic [5:0] e;
        e = {2'(drv[2]), 2'(drv[1]), 2'(drv[0])};
        for (int n = 0; n < 12; n++)
        begin
            reg_rd(MAUA_ADDR_STATUS);
            if (q[9:4] === e)
                break;
        end
        check(q[9:4], e);
        check(coil, drv[1] != 0);
        check(cont, (drv[1] != 0) ^ link);
        if (drv[2] != 2)
            check(snd, drv[2] == 1);
    endtask : chk
    task automatic press(input logic which);
        if (which)
            rsp <= ~pol[1];
        else
            acc <= ~pol[0];
        repeat (8) @(posedge clk);
        rsp <= pol[1];
        acc <= pol[0];
        repeat (8) @(posedge clk);
    endtask : press
    // Skip the first high phase, it may be cut short by the shared timer
    task automatic pulse_chk();
        int n;
        int h;
        h = 0;
        for (n = 0; n < 20 && tr !== 1'b0; n++)
            @(posedge clk);
        for (n = 0; n < 20 && tr !== 1'b1; n++)
            @(posedge clk);
        while (tr === 1'b1 && h < 20)
        begin
            @(posedge clk);
            h++;
        end
        check(h, HALF);
    endtask : pulse_chk
    task automatic cycle(input int ch, input int k);
        maua_rack_model_inst.raise(ch, k);
        mdl(0, 8'h01 << k);
        chk();
        press(1'b0);
        mdl(2, 8'h00);
        chk();
    endtask : cycle
    initial
    begin
        repeat (50000) @(posedge clk);
        failures++;
        wrap_up();
    end
    initial
    begin
        act[0] = {MAUA_ACT_STEADY, MAUA_ACT_KEEP, MAUA_ACT_PULSE};
        act[1] = {MAUA_ACT_OFF, MAUA_ACT_KEEP, MAUA_ACT_STEADY};
        act[2] = act[1];
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int o = 0; o < 3; o++)
        begin
            reg_rd(MAUA_ADDR_MASK0 + 8'(4 * o));
            check(q, 32'hff);
            reg_rd(MAUA_ADDR_ACT0 + 8'(4 * o));
            check(q, {26'h0, act[o]});
        end
        reg_rd(MAUA_ADDR_CTRL);
        check(q, 32'h0);
        $display("reset values done");
        for (int k = 0; k < 8; k++)
            cycle(k % 4, k);
        for (int k = 0; k < 8; k++)
            maua_rack_model_inst.fall(k % 4, k, 1'b0);
        maua_rack_model_inst.raise(0, 2);
        mdl(0, 8'h04);
        chk();
        pulse_chk();
        maua_rack_model_inst.fall(0, 2, 1'b0);
        press(1'b0);
        mdl(2, 8'h00);
        chk();
        $display("default actions done");
        maua_rack_model_inst.raise(2, 7);
        mdl(0, 8'h80);
        chk();
        maua_rack_model_inst.fall(2, 7, 1'b1);
        mdl(2, 8'h00);
        press(1'b1);
        chk();
        check(kinds, 32'h0);
        $display("master reset done");
        for (int i = 0; i < 5; i++)
        begin
            r = xorshift();
            msk[1] = r[7:0];
            reg_wr(MAUA_ADDR_MASK0 + 8'h04, {24'h0, r[7:0]});
            cycle(3, int'(r[10:8]));
            maua_rack_model_inst.fall(3, int'(r[10:8]), 1'b0);
        end
        reg_wr(MAUA_ADDR_MASK0 + 8'h04, 32'hff);
        msk[1] = 8'hff;
        $display("random masks done");
        link <= 1'b1;
        for (int a = 0; a < 4; a++)
        begin
            act[2] = {MAUA_ACT_OFF, MAUA_ACT_KEEP, 2'(a)};
            reg_wr(MAUA_ADDR_ACT0 + 8'h08, {26'h0, act[2]});
            cycle(1, 5);
            maua_rack_model_inst.fall(1, 5, 1'b0);
        end
        $display("action codes done");
        // Pins flip at the write edge so the filter hides the crossover
        reg_wr(MAUA_ADDR_CTRL, 32'h3);
        acc <= 1'b1;
        rsp <= 1'b1;
        pol = 2'h3;
        cycle(0, 6); // Panel taken as absent here
        // Earlier master reset left its status bit set
        reg_wr(MAUA_ADDR_IRQ_STAT, 32'h1f);
        press(1'b1);
        reg_rd(MAUA_ADDR_IRQ_STAT);
        check(q[3], 1'b1);
        // Clear event must land before the status clear below
        maua_rack_model_inst.fall(0, 6, 1'b0);
        reg_wr(MAUA_ADDR_CTRL, 32'h0);
        acc <= 1'b0;
        rsp <= 1'b0;
        pol = 2'h0;
        $display("polarity done");
        reg_wr(MAUA_ADDR_IRQ_STAT, 32'h1f);
        reg_rd(8'h40);
        check(q, 32'h0);
        check(irq, 1'b0);
        reg_wr(MAUA_ADDR_IRQ_MASK, 32'h10);
        reg_rd(MAUA_ADDR_IRQ_STAT);
        check(q[4:0], 5'h10);
        check(irq, 1'b1);
        reg_wr(MAUA_ADDR_IRQ_STAT, 32'h10);
        reg_rd(MAUA_ADDR_IRQ_STAT);
        check(q, 32'h0);
        check(irq, 1'b0);
        reg_wr(MAUA_ADDR_CTRL, 32'h100);
        reg_rd(MAUA_ADDR_IRQ_STAT);
        check(q[4:0], 5'h04);
        $display("interrupt done");
        wrap_up();
    end
endmodule : maua_top_tb
bind maua_top maua_monitor #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) maua_monitor_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reset_pin_i(reset_pin_i),
    .relay_nc_link_i(relay_nc_link_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .transistor_on_o(transistor_on_o),
    .panel_lamp_o(panel_lamp_o), .relay_coil_o(relay_coil_o),
    .relay_contact_closed_o(relay_contact_closed_o), .master_reset_o(master_reset_o));
